// ---- hdl/mis_pkg.sv ----
// Operation
// - OR work register with R, d selects destination
// - Copy work register into io page register
// - Copy io page register into work register
// - Long jump loads 11-bit address, two cycles
// - Long call pushes PC+1, then jumps
// - Push stores at level, then pointer increments
// - Store work register into data register R
package mis_pkg;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int RADDR_W = 7;
  localparam int FADDR_W = 4;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam logic [3:0] IO_FIRST = 4'h5;
  localparam logic [3:0] IO_LAST = 4'hF;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic READY_RESET = 1'b1;

  typedef enum logic [2:0] {
    MIS_OP_NONE = 3'b000,
    MIS_OP_OR_WORK_WITH_REG = 3'b001,
    MIS_OP_WRITE_IO_PAGE_REG = 3'b010,
    MIS_OP_READ_IO_PAGE_REG = 3'b011,
    MIS_OP_LONG_JUMP = 3'b100,
    MIS_OP_LONG_CALL = 3'b101,
    MIS_OP_STORE_WORK_TO_REG = 3'b110
  } mis_op_type;

  typedef enum logic [0:0] {
    MIS_ST_EXEC = 1'b0,
    MIS_ST_BRANCH2 = 1'b1
  } mis_state_type;

  // Decoded instruction as handed over by the core's decoder
  typedef struct packed {
    mis_op_type op;
    logic dest_reg;
    logic [6:0] reg_addr;
    logic [3:0] io_addr;
    logic [10:0] target;
  } mis_instr_type;

  // Write strobe toward the data memory or the io page
  typedef struct packed {
    logic data_we;
    logic [6:0] data_addr;
    logic io_we;
    logic [3:0] io_addr;
    logic [7:0] wdata;
  } mis_write_type;
endpackage

// ---- hdl/mis_exec.sv ----
`timescale 1ns/1ps
module mis_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction in
  input wire logic instr_valid,
  input mis_pkg::mis_instr_type instr,
  output logic instr_ready,
  // Operand read data, same cycle as instr
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] io_rdata,
  // Writes out
  output mis_pkg::mis_write_type wr,
  // Core state
  output logic [10:0] pc,
  output logic [7:0] work_reg,
  output logic zero_flag,
  output logic [2:0] stack_ptr,
  output logic [10:0] stack_top
);
  import mis_pkg::*;

  // Sequencing
  mis_state_type state;
  mis_state_type next_state;
  logic [10:0] next_pc;
  logic next_instr_ready;

  // Working register and zero flag
  logic [7:0] next_work_reg;
  logic next_zero_flag;

  // Stack
  logic [10:0] stack [STACK_DEPTH];
  logic [2:0] next_stack_ptr;
  logic [10:0] next_stack_top;
  logic push;

  // Write strobe
  mis_write_type next_wr;

  // Decode
  logic take;
  logic do_or;
  logic do_io_write;
  logic do_io_read;
  logic do_store;
  logic do_jump;
  logic do_call;
  logic steps_pc;
  logic io_ok;
  logic [7:0] or_result;
  logic [10:0] pc_plus_one;

  // Only the exec state takes a word; the dead branch cycle refuses it
  assign take = instr_valid && (state == MIS_ST_EXEC);
  assign or_result = work_reg | reg_rdata;
  // Page addresses below the first io register are not decoded
  assign io_ok = (instr.io_addr >= IO_FIRST) && (instr.io_addr <= IO_LAST);
  assign pc_plus_one = pc + 11'h001;

  // Decode: one strobe per executed operation
  always_comb begin
    do_or = 1'b0;
    do_io_write = 1'b0;
    do_io_read = 1'b0;
    do_store = 1'b0;
    do_jump = 1'b0;
    do_call = 1'b0;
    if (take) begin
      case (instr.op)
        MIS_OP_OR_WORK_WITH_REG: begin
          do_or = 1'b1;
        end
        MIS_OP_WRITE_IO_PAGE_REG: begin
          do_io_write = 1'b1;
        end
        MIS_OP_READ_IO_PAGE_REG: begin
          do_io_read = 1'b1;
        end
        MIS_OP_STORE_WORK_TO_REG: begin
          do_store = 1'b1;
        end
        MIS_OP_LONG_JUMP: begin
          do_jump = 1'b1;
        end
        MIS_OP_LONG_CALL: begin
          do_call = 1'b1;
        end
        // None and unused codes execute nothing and hold the PC
        default: begin
        end
      endcase
    end
  end

  assign steps_pc = do_or || do_io_write || do_io_read || do_store;

  // Sequencing: PC, branch state and ready
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_instr_ready = 1'b1;
    case (state)
      MIS_ST_EXEC: begin
        // Jump and call share the two-cycle path
        if (do_jump || do_call) begin
          next_pc = instr.target;
          next_state = MIS_ST_BRANCH2;
          next_instr_ready = 1'b0;
        end else if (steps_pc) begin
          next_pc = pc_plus_one;
        end
      end
      // Second cycle of a branch: the prefetched word is discarded
      MIS_ST_BRANCH2: begin
        next_state = MIS_ST_EXEC;
      end
      default: begin
        next_state = MIS_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= MIS_ST_EXEC;
      pc <= PC_RESET;
      instr_ready <= READY_RESET;
    end else begin
      state <= next_state;
      pc <= next_pc;
      instr_ready <= next_instr_ready;
    end
  end

  // Working register and zero flag
  always_comb begin
    next_work_reg = work_reg;
    next_zero_flag = zero_flag;
    if (do_or) begin
      // Zero follows the OR result for either destination
      next_zero_flag = (or_result == DATA_RESET);
      if (!instr.dest_reg) begin
        next_work_reg = or_result;
      end
    end
    if (do_io_read && io_ok) begin
      next_work_reg = io_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      work_reg <= DATA_RESET;
      zero_flag <= ZERO_RESET;
    end else begin
      work_reg <= next_work_reg;
      zero_flag <= next_zero_flag;
    end
  end

  // Stack pointer and last return address
  always_comb begin
    push = do_call;
    next_stack_ptr = stack_ptr;
    next_stack_top = stack_top;
    if (push) begin
      next_stack_top = pc_plus_one;
      // Pointer wraps after eight levels; a deeper call overwrites the oldest
      next_stack_ptr = stack_ptr + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stack_ptr <= SP_RESET;
      stack_top <= PC_RESET;
    end else begin
      stack_ptr <= next_stack_ptr;
      stack_top <= next_stack_top;
    end
  end

  // Stack storage has no reset; only the pointer defines its contents.
  // It is kept for the return path, which lies outside this block.
  always_ff @(posedge clk) begin
    if (push) begin
      stack[stack_ptr] <= next_stack_top;
    end
  end

  // Write strobe toward the data memory and the io page
  always_comb begin
    next_wr = '0;
    if (do_or && instr.dest_reg) begin
      next_wr.data_we = 1'b1;
      next_wr.data_addr = instr.reg_addr;
      next_wr.wdata = or_result;
    end
    if (do_io_write) begin
      // Out-of-range page addresses are dropped rather than aliased
      next_wr.io_we = io_ok;
      next_wr.io_addr = instr.io_addr;
      next_wr.wdata = work_reg;
    end
    // Store leaves work_reg and zero_flag alone
    if (do_store) begin
      next_wr.data_we = 1'b1;
      next_wr.data_addr = instr.reg_addr;
      next_wr.wdata = work_reg;
    end
  end

  // One-cycle strobe; the memories latch it on the following edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr <= '0;
    end else begin
      wr <= next_wr;
    end
  end
endmodule // mis_exec

// ---- bench/mis_exec_properties.sv ----
`timescale 1ns/1ps
module mis_exec_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction in
  input wire logic instr_valid,
  input mis_pkg::mis_instr_type instr,
  input wire logic instr_ready,
  // Operand read data
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] io_rdata,
  // Writes out
  input mis_pkg::mis_write_type wr,
  // Core state
  input wire logic [10:0] pc,
  input wire logic [7:0] work_reg,
  input wire logic zero_flag,
  input wire logic [2:0] stack_ptr,
  input wire logic [10:0] stack_top
);
  import mis_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  mis_op_type o;
  wire io_ok = instr.io_addr >= IO_FIRST;
  // Operation taken at this edge; refused words read as none
  assign o = (instr_valid && instr_ready) ? instr.op : MIS_OP_NONE;
  AST_OR_W:
  assert property (o == MIS_OP_OR_WORK_WITH_REG && !instr.dest_reg
    |=> work_reg == ($past(work_reg) | $past(reg_rdata)) && zero_flag == (work_reg == 8'h00))
    else $error("or into work register");
  AST_OR_R:
  assert property (o == MIS_OP_OR_WORK_WITH_REG && instr.dest_reg |=> wr.data_we
    && zero_flag == (wr.wdata == 8'h00)) else $error("or reg");
  AST_IO_WR:
  assert property (o == MIS_OP_WRITE_IO_PAGE_REG && io_ok |=> wr.io_we
    && wr.io_addr == $past(instr.io_addr) && wr.wdata == $past(work_reg)
    && $stable(zero_flag)) else $error("io write");
  AST_IO_RD:
  assert property (o == MIS_OP_READ_IO_PAGE_REG && io_ok
    |=> work_reg == $past(io_rdata) && !wr.io_we && $stable(zero_flag)) else $error("io read");
  AST_JUMP:
  assert property (o == MIS_OP_LONG_JUMP |=> pc == $past(instr.target) && !instr_ready
    ##1 instr_ready) else $error("jump");
  AST_CALL:
  assert property (o == MIS_OP_LONG_CALL |=> stack_top == $past(pc) + 11'h001
    && stack_ptr == $past(stack_ptr) + 3'h1 && pc == $past(instr.target)) else $error("call");
  AST_STORE:
  assert property (o == MIS_OP_STORE_WORK_TO_REG |=> wr.data_we
    && wr.wdata == $past(work_reg) && $stable(work_reg)) else $error("store");
  AST_PC:
  assert property (o inside {MIS_OP_OR_WORK_WITH_REG, MIS_OP_WRITE_IO_PAGE_REG,
    MIS_OP_READ_IO_PAGE_REG, MIS_OP_STORE_WORK_TO_REG}
    |=> pc == $past(pc) + 11'h001) else $error("pc step");
  cover property (o == MIS_OP_LONG_CALL);
  cover property (o == MIS_OP_OR_WORK_WITH_REG && instr.dest_reg);
  cover property (o == MIS_OP_READ_IO_PAGE_REG && !io_ok);
endmodule // mis_exec_properties
bind mis_exec mis_exec_properties chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .instr_valid(instr_valid),
  .instr(instr),
  .instr_ready(instr_ready),
  .reg_rdata(reg_rdata),
  .io_rdata(io_rdata),
  .wr(wr),
  .pc(pc),
  .work_reg(work_reg),
  .zero_flag(zero_flag),
  .stack_ptr(stack_ptr),
  .stack_top(stack_top)
);

// ---- bench/mis_exec_tb.sv ----
`timescale 1ns/1ps
module mis_exec_tb;
  import mis_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, instr_ready, zero_flag, z = 1'b0;
  logic rdy = 1'b1;
  mis_instr_type instr = '0;
  mis_write_type wr;
  logic [7:0] reg_rdata = 8'h00, io_rdata = 8'h00, work_reg, w = 8'h00;
  logic [10:0] pc, stack_top, p = 11'h000, top = 11'h000;
  logic [2:0] stack_ptr, sp = 3'h0;
  logic [31:0] x = 32'h5474;
  logic [55:0] q[$];
  logic [55:0] n;
  wire [55:0] seen;
  int err_count = 0, comparisons = 0;
  assign seen = {instr_ready, pc, work_reg, zero_flag, stack_ptr, stack_top, wr};
  always #2.5 clk = ~clk;
  mis_exec dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .instr_valid(instr_valid),
    .instr(instr),
    .instr_ready(instr_ready),
    .reg_rdata(reg_rdata),
    .io_rdata(io_rdata),
    .wr(wr),
    .pc(pc),
    .work_reg(work_reg),
    .zero_flag(zero_flag),
    .stack_ptr(stack_ptr),
    .stack_top(stack_top)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [55:0] a, input logic [55:0] e);
    comparisons++;
    if (a !== e) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, a, e);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One cycle of stimulus; the model notes what must show after the edge
  task automatic step(input mis_op_type o);
    mis_write_type e;
    logic adv;
    e = '0;
    adv = 1'b0;
    x = lfsr(x);
    instr_valid = |x[27:25];
    instr = {o, x[22:0]};
    reg_rdata = x[31:24] & {8{x[0]}};
    io_rdata = x[15:8];
    if (rdy && instr_valid) begin
      adv = o inside {MIS_OP_OR_WORK_WITH_REG, MIS_OP_WRITE_IO_PAGE_REG,
        MIS_OP_READ_IO_PAGE_REG, MIS_OP_STORE_WORK_TO_REG};
      case (o)
        MIS_OP_OR_WORK_WITH_REG: begin
          z = (w | reg_rdata) == 8'h00;
          if (instr.dest_reg) e = '{1'b1, instr.reg_addr, 1'b0, 4'h0, w | reg_rdata};
          else w = w | reg_rdata;
        end
        MIS_OP_WRITE_IO_PAGE_REG: e = '{1'b0, 7'h00, instr.io_addr >= IO_FIRST,
          instr.io_addr, w};
        MIS_OP_READ_IO_PAGE_REG: if (instr.io_addr >= IO_FIRST) w = io_rdata;
        MIS_OP_STORE_WORK_TO_REG: e = '{1'b1, instr.reg_addr, 1'b0, 4'h0, w};
        MIS_OP_LONG_CALL: begin
          top = p + 11'h001;
          sp = sp + 3'h1;
        end
        default: ;
      endcase
      rdy = o != MIS_OP_LONG_JUMP && o != MIS_OP_LONG_CALL;
      if (!rdy) begin
        p = instr.target;
      end else if (adv) begin
        p = p + 11'h001;
      end
    end else rdy = 1'b1;
    @(posedge clk);
    #1;
    q.push_back({rdy, p, w, z, sp, top, e});
  endtask
  // Mid-run reset: every output must return to its reset value
  task automatic reset_test;
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    rdy = READY_RESET;
    p = PC_RESET;
    w = DATA_RESET;
    z = ZERO_RESET;
    sp = SP_RESET;
    top = PC_RESET;
    @(posedge clk);
    #1;
    q.push_back({rdy, p, w, z, sp, top, 21'h000000});
    sys_rst = 1'b0;
  endtask
  always @(negedge clk) begin
    if (q.size() > 0) begin
      n = q.pop_front();
      chk(56'(seen[55:21]), 56'(n[55:21]));
      chk(56'(seen[20:0]), 56'(n[20:0]));
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) step(mis_op_type'(i[2:0]));
    $display("test ops done");
    repeat (400) begin
      x = lfsr(x);
      step(mis_op_type'(x[2:0]));
    end
    $display("test random done");
    reset_test();
    repeat (40) begin
      x = lfsr(x);
      step(mis_op_type'(x[2:0]));
    end
    $display("test reset done");
    repeat (2) @(negedge clk);
    end_of_test();
  end
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule // mis_exec_tb
